// ===== inc/vector_map_pkg.sv
package vector_map_pkg;
   localparam int ADDR_W            = 12;
   localparam int NUM_SOURCES       = 25;
   localparam int SRC_IDX_W         = 5;
   localparam logic [11:0] RESET_VECTOR_ADDR = 12'h000;
   localparam logic [11:0] IRQ_TABLE_BASE    = 12'h001;
   localparam logic [11:0] BOOT_RESET_ADDR_DEF = 12'hC00;
   localparam logic        FUSE_PROGRAMMED   = 1'h0;
   // source index n (bit n of the request vector) sits at IRQ_TABLE_BASE + n
   localparam int SRC_EXT_REQ0      = 0;
   localparam int SRC_WATCHDOG      = 5;
   localparam int SRC_TIMER2_COMPA  = 6;
   localparam int SRC_TIMER1_CAPT   = 9;
   localparam int SRC_TIMER0_COMPA  = 13;
   localparam int SRC_SERIAL_XFER   = 16;
   localparam int SRC_CONV_DONE     = 20;
   localparam int SRC_DATA_NVM_RDY  = 21;
   localparam int SRC_PROG_STORE_RDY = 24;
endpackage : vector_map_pkg

// ===== core/lowest_pending_pick.sv
module lowest_pending_pick
   import vector_map_pkg::*;
#(
   parameter int N   = NUM_SOURCES,
   parameter int IDX = SRC_IDX_W
) (
   input  wire logic [N-1:0]   req_i,
   output logic                any_o,
   output logic [IDX-1:0]      idx_o
);
   logic [IDX-1:0] pick [N:0];
   assign pick[N] = '0;
   genvar g;
   generate
      // walk from the top so the lowest set bit wins
      for (g = N - 1; g >= 0; g--) begin : g_pick
         assign pick[g] = req_i[g] ? IDX'(g) : pick[g+1];
      end
   endgenerate
   assign any_o = |req_i;
   assign idx_o = pick[0];
endmodule : lowest_pending_pick

// ===== core/reset_interrupt_vector_map.sv
// What this block does
// [R1] reset vector is number 1, taken after any reset, word 0x000 with fuse unprogrammed
// [R2] programmed boot-reset fuse moves the reset address to the boot reset address
// [R3] fuse value 1 means unprogrammed, 0 means programmed
// [R4] relocate bit set adds boot section start to every interrupt vector address
// [R5] vectors start at 0x001, or boot reset address plus 0x001, for either fuse
// [R6] one word per vector: ext0, ext1, pin-change 0..2, watchdog at 0x001..0x006
// [R7] timer vectors 0x007..0x010: timer2, then timer1, then timer0
// [R8] 0x011..0x015: serial xfer, rx, tx empty, tx complete, conversion done
// [R9] 0x016..0x019: data nvm ready, comparator, two-wire, program store ready
// [R10] vector fetched only when its interrupt is taken
// [R11] unused vector locations in the other section may hold ordinary code
// [R12] lowest vector number pending is serviced first
module reset_interrupt_vector_map
   import vector_map_pkg::*;
#(
   parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = BOOT_RESET_ADDR_DEF
) (
   // clock, reset, enable
   input  wire logic                   REF_CLK_I,
   input  wire logic                   RST_N_I,
   input  wire logic                   CLK_EN_I,
   // configuration
   input  wire logic                   BOOT_RESET_FUSE_I,
   input  wire logic                   VECTOR_RELOCATE_BIT_I,
   // interrupt sources and core global enable
   input  wire logic [NUM_SOURCES-1:0] IRQ_REQ_I,
   input  wire logic                   GLOBAL_IRQ_EN_I,
   // fetch side
   input  wire logic                   VECTOR_ACK_I,
   output logic                        RESET_FETCH_O,
   output logic                        IRQ_TAKE_O,
   output logic [ADDR_W-1:0]           VECTOR_ADDR_O,
   output logic [SRC_IDX_W-1:0]        VECTOR_SRC_O
);
   typedef enum logic [1:0] {S_RESET_VEC, S_IDLE, S_IRQ_VEC} vec_state_t;

   vec_state_t            state;
   vec_state_t            next_state;
   logic                  fuse_q;
   logic [ADDR_W-1:0]     next_addr;
   logic [SRC_IDX_W-1:0]  next_src;

   wire                   any_pending;
   wire [SRC_IDX_W-1:0]   win_idx;

   // strap sampled on each enabled clock while reset is low, held after reset release
   wire fuse_programmed = (fuse_q == FUSE_PROGRAMMED);                    // [R3]
   wire [ADDR_W-1:0] reset_addr =
      fuse_programmed ? BOOT_RESET_ADDR : RESET_VECTOR_ADDR;              // [R1] [R2]
   // relocation is independent of the fuse
   wire [ADDR_W-1:0] table_base =
      VECTOR_RELOCATE_BIT_I ? ADDR_W'(BOOT_RESET_ADDR + IRQ_TABLE_BASE)
                            : IRQ_TABLE_BASE;                             // [R4] [R5]
   // contiguous one-word table; source order is the request bit order
   wire [ADDR_W-1:0] irq_addr = ADDR_W'(table_base + ADDR_W'(win_idx));   // [R6] [R7] [R8] [R9]
   wire take_irq = GLOBAL_IRQ_EN_I && any_pending;                        // [R10]

   lowest_pending_pick #(
      .N   (NUM_SOURCES),
      .IDX (SRC_IDX_W)
   ) u_pick (
      .req_i (IRQ_REQ_I),
      .any_o (any_pending),
      .idx_o (win_idx)
   );                                                                     // [R12]

   always_comb begin
      next_state = state;
      next_addr  = VECTOR_ADDR_O;
      next_src   = VECTOR_SRC_O;
      unique case (state)
         S_RESET_VEC: begin
            next_addr = reset_addr;                                       // [R1]
            if (VECTOR_ACK_I) begin
               next_state = S_IDLE;
            end
         end
         S_IDLE: begin
            // no fetch request otherwise, so table words stay free for code
            if (take_irq) begin                                           // [R10] [R11]
               next_state = S_IRQ_VEC;
               next_addr  = irq_addr;
               next_src   = win_idx;
            end
         end
         S_IRQ_VEC: begin
            if (VECTOR_ACK_I) begin
               next_state = S_IDLE;
            end
         end
         default: next_state = S_RESET_VEC;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         state         <= S_RESET_VEC;
         VECTOR_ADDR_O <= RESET_VECTOR_ADDR;
         VECTOR_SRC_O  <= '0;
      end else if (CLK_EN_I) begin
         state         <= next_state;
         VECTOR_ADDR_O <= next_addr;
         VECTOR_SRC_O  <= next_src;
      end
   end

   // fuse sampled during reset so the first vector after release is right
   always_ff @(posedge REF_CLK_I) begin
      if (CLK_EN_I && !RST_N_I) begin
         fuse_q <= BOOT_RESET_FUSE_I;
      end
   end

   assign RESET_FETCH_O = (state == S_RESET_VEC);
   assign IRQ_TAKE_O    = (state == S_IRQ_VEC);
endmodule : reset_interrupt_vector_map

// ===== dv/vector_map_props.sv
module vector_map_props
   import vector_map_pkg::*;
#(parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = BOOT_RESET_ADDR_DEF) (
   input wire logic REF_CLK_I, RST_N_I, BOOT_RESET_FUSE_I, VECTOR_RELOCATE_BIT_I,
   input wire logic [NUM_SOURCES-1:0] IRQ_REQ_I,
   input wire logic GLOBAL_IRQ_EN_I, VECTOR_ACK_I, RESET_FETCH_O, IRQ_TAKE_O,
   input wire logic [ADDR_W-1:0] VECTOR_ADDR_O,
   input wire logic [SRC_IDX_W-1:0] VECTOR_SRC_O);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   AST_RST_OFFER: assert property ($rose(RST_N_I) |-> RESET_FETCH_O) else $error("rst");
   AST_RST_ADDR: assert property ($rose(RST_N_I) |=> VECTOR_ADDR_O ==
      (BOOT_RESET_FUSE_I ? RESET_VECTOR_ADDR : BOOT_RESET_ADDR)) else $error("rst addr");
   AST_HOLD: assert property ((IRQ_TAKE_O || RESET_FETCH_O) && !VECTOR_ACK_I
      && $past(RST_N_I) |=> $stable({IRQ_TAKE_O, RESET_FETCH_O, VECTOR_ADDR_O})) else $error("hold");
   AST_IRQ_ADDR: assert property ($rose(IRQ_TAKE_O) |->
      VECTOR_ADDR_O == ($past(VECTOR_RELOCATE_BIT_I) ? BOOT_RESET_ADDR : 12'h000)
      + IRQ_TABLE_BASE + VECTOR_SRC_O) else $error("irq addr");
   AST_LOWEST: assert property ($rose(IRQ_TAKE_O) |-> ($past(IRQ_REQ_I) &
      ((25'h1 << (VECTOR_SRC_O + 5'h1)) - 25'h1)) == 25'h1 << VECTOR_SRC_O) else $error("order");
   AST_TAKE_EN: assert property ($rose(IRQ_TAKE_O) |-> $past(GLOBAL_IRQ_EN_I)) else $error("en");
   AST_NO_TAKE: assert property (!GLOBAL_IRQ_EN_I && !IRQ_TAKE_O |=> !IRQ_TAKE_O)
      else $error("take");
   AST_ACK: assert property ((IRQ_TAKE_O || RESET_FETCH_O) && VECTOR_ACK_I && $past(RST_N_I)
      |=> !IRQ_TAKE_O && !RESET_FETCH_O) else $error("ack");
endmodule : vector_map_props
bind reset_interrupt_vector_map vector_map_props #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) props (.*);

// ===== dv/core_fetch_model.sv
module core_fetch_model (
   input  wire logic       REF_CLK_I, RST_N_I, RESET_FETCH_O, IRQ_TAKE_O,
   input  wire logic [1:0] WAIT_I,
   output logic            VECTOR_ACK_I = 1'b0);
   timeunit 1ns; timeprecision 1ns;
   logic [2:0] cnt = 3'h0;
   // slow fetch keeps the vector offered for WAIT_I extra cycles
   always @(posedge REF_CLK_I) begin
      #1;
      // a core held in reset fetches nothing, so no acknowledge before release
      cnt = RST_N_I && (RESET_FETCH_O || IRQ_TAKE_O) && !VECTOR_ACK_I ? cnt + 3'h1 : 3'h0;
      VECTOR_ACK_I = cnt > WAIT_I;
   end
endmodule : core_fetch_model

// ===== dv/reset_interrupt_vector_map_bench.sv
module reset_interrupt_vector_map_bench;
   import vector_map_pkg::*;
   timeunit 1ns; timeprecision 1ns;
   logic REF_CLK_I, RST_N_I, CLK_EN_I = 1'h1, BOOT_RESET_FUSE_I, VECTOR_RELOCATE_BIT_I;
   logic GLOBAL_IRQ_EN_I, VECTOR_ACK_I, RESET_FETCH_O, IRQ_TAKE_O;
   logic [NUM_SOURCES-1:0] IRQ_REQ_I;
   logic [ADDR_W-1:0] VECTOR_ADDR_O;
   logic [SRC_IDX_W-1:0] VECTOR_SRC_O;
   logic [1:0] WAIT_I;
   int bad_count, n_checks;
   reset_interrupt_vector_map uut (.*);
   core_fetch_model core (.*);
   task chk(string what, logic [11:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task give_verdict;
      if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task step(int n);
      repeat (n) @(posedge REF_CLK_I);
      #1;
   endtask : step
   task reset_fetch(logic f);
      {RST_N_I, BOOT_RESET_FUSE_I, WAIT_I} = {1'b0, f, 2'h3};
      step(12);
      RST_N_I = 1'b1;
      step(1);
      chk("reset", f ? RESET_VECTOR_ADDR : BOOT_RESET_ADDR_DEF, VECTOR_ADDR_O);
      chk("offer", 12'h1, 12'(RESET_FETCH_O));
      step(6);
      chk("offer done", 12'h0, 12'(RESET_FETCH_O));
   endtask : reset_fetch
   // bounded waits: a lost vector shows as a mismatch, not a hang
   task take_irq(logic [24:0] r, int n, logic rl);
      {IRQ_REQ_I, VECTOR_RELOCATE_BIT_I, GLOBAL_IRQ_EN_I, WAIT_I} = {r, rl, 1'b1, 2'(n)};
      for (int i = 0; i < 9 && IRQ_TAKE_O !== 1'b1; i++) step(1);
      chk("src", 12'(n), 12'(VECTOR_SRC_O));
      chk("addr", (rl ? BOOT_RESET_ADDR_DEF : 12'h0) + IRQ_TABLE_BASE + 12'(n), VECTOR_ADDR_O);
      IRQ_REQ_I[n] = 1'b0;
      for (int i = 0; i < 9 && IRQ_TAKE_O === 1'b1; i++) step(1);
   endtask : take_irq
   // a low enable must freeze the block even with a request pending
   task hold_frozen;
      {CLK_EN_I, GLOBAL_IRQ_EN_I, IRQ_REQ_I} = {1'b0, 1'b1, 25'h20};
      step(3);
      chk("frozen", 12'h0, 12'(IRQ_TAKE_O));
      CLK_EN_I = 1'b1;
      take_irq(IRQ_REQ_I, 5, 1'b0);
   endtask : hold_frozen
   initial begin
      REF_CLK_I = 1'b0;
      forever #50 REF_CLK_I = ~REF_CLK_I;
   end
   initial begin
      {VECTOR_RELOCATE_BIT_I, GLOBAL_IRQ_EN_I, IRQ_REQ_I} = '0;
      for (int f = 1; f >= 0; f--) begin
         reset_fetch(f[0]);
         for (int k = 0; k < 50; k++) take_irq(25'h1 << k % 25, k % 25, k > 24);
      end
      take_irq(25'h1010200, 9, 1'b0);
      take_irq(IRQ_REQ_I, 16, 1'b0);
      take_irq(IRQ_REQ_I, 24, 1'b1);
      {GLOBAL_IRQ_EN_I, IRQ_REQ_I} = {1'b0, 25'h8};
      step(4);
      chk("refused", 12'h0, 12'(IRQ_TAKE_O));
      take_irq(IRQ_REQ_I, 3, 1'b1);
      hold_frozen;
      give_verdict;
   end
   initial begin
      #1000000;
      bad_count++;
      give_verdict;
   end
endmodule : reset_interrupt_vector_map_bench
